// *** verilog/gpm_top.sv ***
// Power-mode sequencer, conversion scheduler, touch state and gesture flag registers.
`timescale 1ns/1ns
module gpm_top #(
  parameter int unsigned MS_CYCLES = gpm_pkg::MS_CYCLES
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register access from the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rd_first,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Sensor results
  input wire gpm_pkg::gpm_sense_t sense,
  // Conversion scheduling and mode
  output gpm_pkg::gpm_conv_t conv,
  output gpm_pkg::gpm_mode_t power_mode
);

  if (MS_CYCLES < 1 || MS_CYCLES > (1 << gpm_pkg::MS_DIV_WIDTH)) begin : g_bad_ms
    $error("MS_CYCLES out of range for the millisecond divider");
  end

  gpm_pkg::gpm_top_st_t s_r;
  gpm_pkg::gpm_top_st_t s_nxt;

  logic ms_tick;
  logic magnetic_hit;
  logic trackpad_hit;
  logic event_now;
  logic [16:0] step_limit;
  logic [7:0] interval;
  logic [1:0] seg_last;
  logic [gpm_pkg::GST_WIDTH-1:0] gest_set;
  logic [1:0] manual_mode;

  // ****************************************
  // Gesture recogniser
  // ****************************************
  // Coordinate span is produced upstream; the recogniser treats both axes as 0-255.
  gpm_gesture u_gesture (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .ms_tick(ms_tick),
    .touch(s_r.channel_touch_state[gpm_pkg::TOUCH_TRACKPAD_BIT]),
    .x_coord(sense.x_coord),
    .y_coord(sense.y_coord),
    .threshold(s_r.general_settings_gesture_threshold[15:8]),
    .tap_timeout(s_r.gesture_timeouts[7:0]),
    .swipe_timeout(s_r.gesture_timeouts[15:8]),
    .swipe_select(s_r.general_settings_gesture_threshold[gpm_pkg::GENERAL_SWIPE_SELECT_BIT]),
    .gest_set(gest_set)
  );

  // ****************************************
  // Combinational terms
  // ****************************************
  always_comb begin
    ms_tick = (s_r.ms_div == gpm_pkg::MS_DIV_WIDTH'(MS_CYCLES - 1));
    magnetic_hit = (sense.magnetic_output > sense.magnetic_threshold);
    trackpad_hit = |(sense.trackpad_over & sense.trackpad_active);
    event_now = sense.other_event | magnetic_hit | trackpad_hit;
    step_limit = {s_r.ultra_low_rate_and_timer[15:8], gpm_pkg::STEP_SHIFT'(0)};
    seg_last = s_r.power_mode_settings[gpm_pkg::PWR_SEGMENT_LSB +: 2];
    manual_mode = s_r.power_mode_settings[gpm_pkg::PWR_MANUAL_MODE_LSB +: 2];
    case (s_r.mode)
      gpm_pkg::reduced_rate_mode: interval = s_r.normal_low_report_rates[15:8];
      gpm_pkg::minimal_rate_mode: interval = s_r.ultra_low_rate_and_timer[7:0];
      default: interval = s_r.normal_low_report_rates[7:0];
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.conv = '0;
    s_nxt.ms_div = ms_tick ? '0 : s_r.ms_div + 1'b1;

    s_nxt.channel_touch_state = '0;
    s_nxt.channel_touch_state[gpm_pkg::TOUCH_MAGNETIC_BIT] = magnetic_hit;
    s_nxt.channel_touch_state[gpm_pkg::TOUCH_TRACKPAD_BIT] = trackpad_hit;

    // Power mode sequencing.
    if (!s_r.power_mode_settings[gpm_pkg::PWR_AUTO_SWITCH_BIT]) begin
      s_nxt.idle_ms = '0;
      case (manual_mode)
        2'b01: s_nxt.mode = gpm_pkg::reduced_rate_mode;
        2'b10: s_nxt.mode = gpm_pkg::minimal_rate_mode;
        default: s_nxt.mode = gpm_pkg::full_rate_mode;
      endcase
    end else begin
      case (s_r.mode)
        gpm_pkg::full_rate_mode: begin
          if (event_now) begin
            s_nxt.idle_ms = '0;
          end else if (ms_tick) begin
            if (s_r.idle_ms >= step_limit) begin
              s_nxt.mode = gpm_pkg::reduced_rate_mode;
              s_nxt.idle_ms = '0;
            end else begin
              s_nxt.idle_ms = s_r.idle_ms + 17'h00001;
            end
          end
        end
        gpm_pkg::reduced_rate_mode: begin
          if (event_now) begin
            s_nxt.mode = gpm_pkg::full_rate_mode;
            s_nxt.idle_ms = '0;
          end else if (ms_tick) begin
            if (s_r.idle_ms >= step_limit) begin
              if (s_r.power_mode_settings[gpm_pkg::PWR_MINIMAL_ENABLE_BIT]) begin
                s_nxt.mode = gpm_pkg::minimal_rate_mode;
                s_nxt.idle_ms = '0;
              end
            end else begin
              s_nxt.idle_ms = s_r.idle_ms + 17'h00001;
            end
          end
        end
        gpm_pkg::minimal_rate_mode: begin
          if (event_now) begin
            s_nxt.mode = gpm_pkg::full_rate_mode;
            s_nxt.idle_ms = '0;
          end
        end
        default: begin
          s_nxt.mode = gpm_pkg::full_rate_mode;
          s_nxt.idle_ms = '0;
        end
      endcase
    end

    // Report cycle scheduling; an interval of zero is served as one millisecond.
    if (s_nxt.mode != s_r.mode) begin
      s_nxt.rate_ms = '0;
      s_nxt.seg_cnt = '0;
    end else if (ms_tick) begin
      if (s_r.rate_ms + 8'h01 >= interval) begin
        s_nxt.rate_ms = '0;
        s_nxt.conv.start = 1'b1;
        s_nxt.conv.channel0 = 1'b1;
        if (s_r.mode == gpm_pkg::minimal_rate_mode) begin
          s_nxt.conv.others = (s_r.seg_cnt == 2'b00);
          s_nxt.seg_cnt = (s_r.seg_cnt >= seg_last) ? 2'b00 : s_r.seg_cnt + 2'b01;
        end else begin
          s_nxt.conv.others = 1'b1;
          s_nxt.seg_cnt = '0;
        end
      end else begin
        s_nxt.rate_ms = s_r.rate_ms + 8'h01;
      end
    end

    // Register writes.
    if (reg_wr) begin
      if (reg_addr == gpm_pkg::ADDR_POWER_MODE) begin
        s_nxt.power_mode_settings = reg_wdata;
      end else if (reg_addr == gpm_pkg::ADDR_REPORT_RATES) begin
        s_nxt.normal_low_report_rates = reg_wdata;
      end else if (reg_addr == gpm_pkg::ADDR_ULP_RATE_TIMER) begin
        s_nxt.ultra_low_rate_and_timer = reg_wdata;
      end else if (reg_addr == gpm_pkg::ADDR_GENERAL_THRESH) begin
        s_nxt.general_settings_gesture_threshold = reg_wdata;
      end else if (reg_addr == gpm_pkg::ADDR_GESTURE_TIMEOUTS) begin
        s_nxt.gesture_timeouts = reg_wdata;
      end
    end

    // Register reads; unmapped addresses return zero.
    if (reg_rd) begin
      if (reg_addr == gpm_pkg::ADDR_GLOBAL_EVENT) begin
        s_nxt.rdata = s_r.global_event_flags;
      end else if (reg_addr == gpm_pkg::ADDR_GESTURE_EVENT) begin
        s_nxt.rdata = s_r.gesture_event_flags;
      end else if (reg_addr == gpm_pkg::ADDR_TOUCH_STATE) begin
        s_nxt.rdata = s_r.channel_touch_state;
      end else if (reg_addr == gpm_pkg::ADDR_POWER_MODE) begin
        s_nxt.rdata = s_r.power_mode_settings;
      end else if (reg_addr == gpm_pkg::ADDR_REPORT_RATES) begin
        s_nxt.rdata = s_r.normal_low_report_rates;
      end else if (reg_addr == gpm_pkg::ADDR_ULP_RATE_TIMER) begin
        s_nxt.rdata = s_r.ultra_low_rate_and_timer;
      end else if (reg_addr == gpm_pkg::ADDR_GENERAL_THRESH) begin
        s_nxt.rdata = s_r.general_settings_gesture_threshold;
      end else if (reg_addr == gpm_pkg::ADDR_GESTURE_TIMEOUTS) begin
        s_nxt.rdata = s_r.gesture_timeouts;
      end else begin
        s_nxt.rdata = '0;
      end
      if (reg_rd_first && reg_addr == gpm_pkg::ADDR_GLOBAL_EVENT) begin
        s_nxt.global_event_flags[gpm_pkg::GLOBAL_GESTURE_BIT] = 1'b0;
        s_nxt.gesture_event_flags = '0;
      end
    end

    // A gesture in the same cycle as the clearing read is kept, so no event is lost.
    if (|gest_set) begin
      s_nxt.global_event_flags[gpm_pkg::GLOBAL_GESTURE_BIT] = 1'b1;
      s_nxt.gesture_event_flags[gpm_pkg::GST_WIDTH-1:0] =
        s_nxt.gesture_event_flags[gpm_pkg::GST_WIDTH-1:0] | gest_set;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.mode <= gpm_pkg::full_rate_mode;
      s_r.power_mode_settings <= gpm_pkg::RST_POWER_MODE;
      s_r.normal_low_report_rates <= gpm_pkg::RST_REPORT_RATES;
      s_r.ultra_low_rate_and_timer <= gpm_pkg::RST_ULP_RATE_TIMER;
      s_r.general_settings_gesture_threshold <= gpm_pkg::RST_GENERAL_THRESH;
      s_r.gesture_timeouts <= gpm_pkg::RST_GESTURE_TIMEOUTS;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Conversion strobes are masked by the enable so a frozen block never repeats a pulse.
  assign conv = clk_en ? s_r.conv : '0;
  assign power_mode = s_r.mode;
  assign reg_rdata = s_r.rdata;

endmodule

// *** verilog/gpm_pkg.sv ***
// Package with register map, field positions, reset values, timing constants and carrier types.
package gpm_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_GLOBAL_EVENT = 8'h02;
  localparam logic [7:0] ADDR_GESTURE_EVENT = 8'h03;
  localparam logic [7:0] ADDR_TOUCH_STATE = 8'h05;
  localparam logic [7:0] ADDR_POWER_MODE = 8'h80;
  localparam logic [7:0] ADDR_REPORT_RATES = 8'h83;
  localparam logic [7:0] ADDR_ULP_RATE_TIMER = 8'h84;
  localparam logic [7:0] ADDR_GENERAL_THRESH = 8'h86;
  localparam logic [7:0] ADDR_GESTURE_TIMEOUTS = 8'h87;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GLOBAL_GESTURE_BIT = 11;
  localparam int TOUCH_TRACKPAD_BIT = 1;
  localparam int TOUCH_MAGNETIC_BIT = 7;
  localparam int GST_X_INCREASE_BIT = 0;
  localparam int GST_X_DECREASE_BIT = 1;
  localparam int GST_Y_INCREASE_BIT = 2;
  localparam int GST_Y_DECREASE_BIT = 3;
  localparam int GST_TAP_BIT = 4;
  localparam int GST_HOLD_BIT = 5;
  localparam int GST_WIDTH = 6;
  localparam int GENERAL_SWIPE_SELECT_BIT = 3;
  localparam int PWR_AUTO_SWITCH_BIT = 0;
  localparam int PWR_MINIMAL_ENABLE_BIT = 1;
  localparam int PWR_SEGMENT_LSB = 2;
  localparam int PWR_MANUAL_MODE_LSB = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_POWER_MODE = 16'h0001;
  localparam logic [15:0] RST_REPORT_RATES = 16'h5010;
  localparam logic [15:0] RST_ULP_RATE_TIMER = 16'h0a40;
  localparam logic [15:0] RST_GENERAL_THRESH = 16'h2000;
  localparam logic [15:0] RST_GESTURE_TIMEOUTS = 16'h6432;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_TIME_MS = 512;
  localparam int STEP_SHIFT = $clog2(STEP_TIME_MS);
  localparam int MS_DIV_WIDTH = 17;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    full_rate_mode = 2'b00,
    reduced_rate_mode = 2'b01,
    minimal_rate_mode = 2'b10
  } gpm_mode_t;

  typedef struct packed {
    logic signed [15:0] magnetic_output;
    logic signed [15:0] magnetic_threshold;
    logic [8:0] trackpad_over;
    logic [8:0] trackpad_active;
    logic other_event;
    logic [7:0] x_coord;
    logic [7:0] y_coord;
  } gpm_sense_t;

  typedef struct packed {
    logic start;
    logic channel0;
    logic others;
  } gpm_conv_t;

  typedef struct packed {
    logic touching;
    logic [7:0] start_x;
    logic [7:0] start_y;
    logic [8:0] elapsed_ms;
    logic swipe_done;
    logic hold_done;
    logic [GST_WIDTH-1:0] gest_set;
  } gpm_gst_st_t;

  typedef struct packed {
    gpm_mode_t mode;
    logic [MS_DIV_WIDTH-1:0] ms_div;
    logic [16:0] idle_ms;
    logic [7:0] rate_ms;
    logic [1:0] seg_cnt;
    logic [15:0] global_event_flags;
    logic [15:0] gesture_event_flags;
    logic [15:0] channel_touch_state;
    logic [15:0] power_mode_settings;
    logic [15:0] normal_low_report_rates;
    logic [15:0] ultra_low_rate_and_timer;
    logic [15:0] general_settings_gesture_threshold;
    logic [15:0] gesture_timeouts;
    logic [15:0] rdata;
    gpm_conv_t conv;
  } gpm_top_st_t;

endpackage

// *** verilog/gpm_gesture.sv ***
// Trackpad gesture recogniser: tap, flick, swipe and hold from touch flag and coordinates.
`timescale 1ns/1ns
module gpm_gesture (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Timing and touch input
  input wire logic ms_tick,
  input wire logic touch,
  input wire logic [7:0] x_coord,
  input wire logic [7:0] y_coord,
  // Limits and swipe select
  input wire logic [7:0] threshold,
  input wire logic [7:0] tap_timeout,
  input wire logic [7:0] swipe_timeout,
  input wire logic swipe_select,
  // One-cycle gesture set pulses
  output logic [gpm_pkg::GST_WIDTH-1:0] gest_set
);

  gpm_pkg::gpm_gst_st_t s_r;
  gpm_pkg::gpm_gst_st_t s_nxt;

  logic signed [8:0] dx;
  logic signed [8:0] dy;
  logic [8:0] adx;
  logic [8:0] ady;
  logic moved;
  logic still;
  logic [gpm_pkg::GST_WIDTH-1:0] dir_bits;

  // ****************************************
  // Movement
  // ****************************************
  always_comb begin
    dx = $signed({1'b0, x_coord}) - $signed({1'b0, s_r.start_x});
    dy = $signed({1'b0, y_coord}) - $signed({1'b0, s_r.start_y});
    adx = dx[8] ? 9'(-dx) : 9'(dx);
    ady = dy[8] ? 9'(-dy) : 9'(dy);
    moved = (adx >= {1'b0, threshold}) || (ady >= {1'b0, threshold});
    // Half threshold compared as doubled movement so an odd threshold is not truncated.
    still = ({adx, 1'b0} <= {2'b00, threshold}) && ({ady, 1'b0} <= {2'b00, threshold});
    dir_bits = '0;
    if (adx >= ady) begin
      dir_bits[dx[8] ? gpm_pkg::GST_X_DECREASE_BIT : gpm_pkg::GST_X_INCREASE_BIT] = 1'b1;
    end else begin
      dir_bits[dy[8] ? gpm_pkg::GST_Y_DECREASE_BIT : gpm_pkg::GST_Y_INCREASE_BIT] = 1'b1;
    end
  end

  // ****************************************
  // Touch event tracking
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.gest_set = '0;
    s_nxt.touching = touch;
    if (touch && !s_r.touching) begin
      s_nxt.start_x = x_coord;
      s_nxt.start_y = y_coord;
      s_nxt.elapsed_ms = '0;
      s_nxt.swipe_done = 1'b0;
      s_nxt.hold_done = 1'b0;
    end else if (touch) begin
      if (ms_tick && s_r.elapsed_ms != 9'h1ff) begin
        s_nxt.elapsed_ms = s_r.elapsed_ms + 9'h001;
      end
      if (swipe_select && !s_r.swipe_done && moved &&
          s_r.elapsed_ms < {1'b0, swipe_timeout}) begin
        s_nxt.gest_set = dir_bits;
        s_nxt.swipe_done = 1'b1;
      end
      if (!s_r.hold_done && s_r.elapsed_ms > {1'b0, tap_timeout} &&
          s_r.elapsed_ms > {1'b0, swipe_timeout}) begin
        s_nxt.gest_set[gpm_pkg::GST_HOLD_BIT] = 1'b1;
        s_nxt.hold_done = 1'b1;
      end
    end else if (s_r.touching) begin
      if (s_r.elapsed_ms < {1'b0, tap_timeout} && still) begin
        s_nxt.gest_set[gpm_pkg::GST_TAP_BIT] = 1'b1;
      end else if (!swipe_select && moved && s_r.elapsed_ms < {1'b0, swipe_timeout}) begin
        s_nxt.gest_set = dir_bits;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign gest_set = clk_en ? s_r.gest_set : '0;

endmodule

// *** dv/gpm_top_props.sv ***
// Concurrent checks on the ports of the power-mode and gesture block.
`timescale 1ns/1ns
module gpm_top_props #(
  parameter int unsigned MS_CYCLES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rd_first,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Sensing, conversion and mode
  input wire gpm_pkg::gpm_sense_t sense,
  input wire gpm_pkg::gpm_conv_t conv,
  input wire gpm_pkg::gpm_mode_t power_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Saturates rather than wraps, so a long quiet spell never looks like a short gap.
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;
  always_comb begin
    gap_nxt = (gap_r == 16'hffff) ? gap_r : gap_r + 16'h0001;
    if (conv.start) begin
      gap_nxt = 16'h0000;
    end
  end
  always_ff @(posedge sys_clk) begin
    gap_r <= rst ? 16'hffff : gap_nxt;
  end
  sequence s_touch_read;
    (clk_en && $stable(sense)) [*3] ##0 (reg_rd && reg_addr == gpm_pkg::ADDR_TOUCH_STATE);
  endsequence
  sequence s_clear_read;
    clk_en && reg_rd && reg_rd_first && reg_addr == gpm_pkg::ADDR_GLOBAL_EVENT &&
    !(|(sense.trackpad_over & sense.trackpad_active));
  endsequence
  chk_mag_touch: assert property (
    s_touch_read |=> reg_rdata[7] ==
    ($past(sense.magnetic_output) > $past(sense.magnetic_threshold))) else $error("magnetic bit");
  chk_pad_touch: assert property (
    s_touch_read |=> reg_rdata[1] ==
    (|($past(sense.trackpad_over) & $past(sense.trackpad_active)))) else $error("pad bit");
  chk_reset_state: assert property (
    $fell(rst) |-> power_mode == gpm_pkg::full_rate_mode && conv == '0) else $error("reset");
  chk_chan0_each: assert property (
    conv.start |-> conv.channel0) else $error("channel 0 missing");
  chk_all_chans: assert property (
    conv.start && power_mode != gpm_pkg::minimal_rate_mode &&
    $past(power_mode) != gpm_pkg::minimal_rate_mode |-> conv.others) else $error("others");
  chk_wake_full: assert property (
    clk_en && sense.other_event && power_mode != gpm_pkg::full_rate_mode |->
    ##[1:2] power_mode == gpm_pkg::full_rate_mode) else $error("no wake");
  chk_mode_step: assert property (
    $changed(power_mode) && power_mode == gpm_pkg::minimal_rate_mode |->
    $past(power_mode) == gpm_pkg::reduced_rate_mode) else $error("bad step");
  chk_flags_clear: assert property (
    s_clear_read ##2 (reg_rd && reg_addr == gpm_pkg::ADDR_GESTURE_EVENT) |=>
    reg_rdata[5:0] == 6'h00) else $error("flags kept");
  chk_conv_gap: assert property (
    conv.start |-> gap_r >= 16'(MS_CYCLES - 1)) else $error("conv too close");
endmodule

bind gpm_top gpm_top_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rd_first(reg_rd_first), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .sense(sense), .conv(conv), .power_mode(power_mode)
);

// *** dv/gpm_host.sv ***
// Host model for the decoded register port: word writes and word reads.
`timescale 1ns/1ns
module gpm_host (
  // Clock
  input wire logic sys_clk,
  // Register port toward the device
  output logic reg_wr,
  output logic reg_rd,
  output logic reg_rd_first,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_rd_first = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  // Released lines show the inverse of the last value, so a stale latch cannot pass.
  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] addr, input logic first, output logic [15:0] data);
    reg_addr = addr;
    reg_rd_first = first;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_rd_first = 1'b0;
    reg_addr = ~addr;
    data = reg_rdata;
    @(posedge sys_clk);
    #1;
  endtask
endmodule

// *** dv/gpm_top_tb.sv ***
// Self-checking bench for the power-mode and gesture block.
`timescale 1ns/1ns
module gpm_top_tb;
  localparam int MSC = 4;
  localparam int LIMIT = 12000;
  logic sys_clk;
  logic rst;
  logic clk_en;
  logic reg_wr;
  logic reg_rd;
  logic reg_rd_first;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  gpm_pkg::gpm_sense_t sense;
  gpm_pkg::gpm_conv_t conv;
  gpm_pkg::gpm_mode_t power_mode;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  gpm_top #(.MS_CYCLES(MSC)) dut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_first(reg_rd_first), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sense(sense), .conv(conv), .power_mode(power_mode)
  );
  gpm_host host (
    .sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_first(reg_rd_first),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] addr, input logic [15:0] exp, input string what);
    logic [15:0] d;
    host.rd(addr, 1'b0, d);
    check(d, exp, what);
  endtask
  // The first gap after a rate write may be odd, so two pulses pass before measuring.
  task automatic conv_gap(input int exp, input string what);
    int n;
    n = 1;
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 200 && conv.start !== 1'b1; i++) tick();
      tick();
    end
    for (int i = 0; i < 200 && conv.start !== 1'b1; i++) begin
      n++;
      tick();
    end
    check(16'(n), 16'(exp), what);
  endtask
  task automatic wait_mode(input gpm_pkg::gpm_mode_t m);
    for (int i = 0; i < 3000 && power_mode !== m; i++) tick();
  endtask
  task automatic gesture(input logic [7:0] x0, y0, x1, y1, input int ms, input logic early,
                         input logic [15:0] exp, input string what);
    logic [15:0] d;
    sense.x_coord = x0;
    sense.y_coord = y0;
    sense.trackpad_over = 9'h001;
    sense.trackpad_active = 9'h001;
    repeat (MSC) tick();
    sense.x_coord = x1;
    sense.y_coord = y1;
    repeat (ms * MSC) tick();
    if (early) begin
      rdchk(gpm_pkg::ADDR_GESTURE_EVENT, exp, what);
    end
    sense.trackpad_over = 9'h000;
    repeat (MSC) tick();
    if (!early) begin
      rdchk(gpm_pkg::ADDR_GESTURE_EVENT, exp, what);
    end
    host.rd(gpm_pkg::ADDR_GLOBAL_EVENT, 1'b1, d);
    check(d & 16'h0800, 16'h0800, what);
    rdchk(gpm_pkg::ADDR_GESTURE_EVENT, 16'h0000, what);
  endtask
  task automatic t_regs();
    rdchk(gpm_pkg::ADDR_POWER_MODE, gpm_pkg::RST_POWER_MODE, "pwr");
    rdchk(gpm_pkg::ADDR_REPORT_RATES, gpm_pkg::RST_REPORT_RATES, "rates");
    rdchk(gpm_pkg::ADDR_ULP_RATE_TIMER, gpm_pkg::RST_ULP_RATE_TIMER, "timer");
    rdchk(gpm_pkg::ADDR_GENERAL_THRESH, gpm_pkg::RST_GENERAL_THRESH, "thr");
    host.wr(gpm_pkg::ADDR_TOUCH_STATE, 16'hffff);
    rdchk(gpm_pkg::ADDR_TOUCH_STATE, 16'h0000, "touch ro");
    rdchk(8'h01, 16'h0000, "unmapped");
  endtask
  task automatic t_power();
    int t0;
    logic [3:0] pat;
    host.wr(gpm_pkg::ADDR_ULP_RATE_TIMER, 16'h0102);
    host.wr(gpm_pkg::ADDR_REPORT_RATES, 16'h0302);
    host.wr(gpm_pkg::ADDR_POWER_MODE, 16'h0007);
    conv_gap(2 * MSC, "full gap");
    sense.other_event = 1'b1;
    tick();
    sense.other_event = 1'b0;
    t0 = cyc;
    wait_mode(gpm_pkg::reduced_rate_mode);
    check(16'(cyc - t0 >= 511 * MSC && cyc - t0 <= 514 * MSC), 16'h0001, "to reduced");
    t0 = cyc;
    conv_gap(3 * MSC, "reduced gap");
    wait_mode(gpm_pkg::minimal_rate_mode);
    check(16'(cyc - t0 >= 511 * MSC && cyc - t0 <= 514 * MSC), 16'h0001, "to minimal");
    conv_gap(2 * MSC, "minimal gap");
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 100 && conv.start !== 1'b1; i++) tick();
      pat[k] = conv.others;
      tick();
    end
    check(16'(pat ^ {pat[2:0], pat[3]}), 16'h000f, "segment");
    sense.other_event = 1'b1;
    tick();
    sense.other_event = 1'b0;
    repeat (2) tick();
    check(16'(power_mode), 16'(gpm_pkg::full_rate_mode), "wake");
  endtask
  task automatic t_gestures();
    host.wr(gpm_pkg::ADDR_GESTURE_TIMEOUTS, 16'h0a05);
    gesture(8'd100, 8'd100, 8'd116, 8'd100, 1, 1'b0, 16'h0010, "tap");
    gesture(8'd100, 8'd100, 8'd132, 8'd100, 3, 1'b0, 16'h0001, "flick +x");
    gesture(8'd100, 8'd100, 8'd60, 8'd100, 3, 1'b0, 16'h0002, "flick -x");
    gesture(8'd100, 8'd100, 8'd110, 8'd140, 3, 1'b0, 16'h0004, "flick +y");
    host.wr(gpm_pkg::ADDR_GENERAL_THRESH, 16'h2008);
    gesture(8'd100, 8'd100, 8'd100, 8'd60, 3, 1'b1, 16'h0008, "swipe -y");
    host.wr(gpm_pkg::ADDR_GENERAL_THRESH, 16'h2000);
    gesture(8'd100, 8'd100, 8'd100, 8'd100, 13, 1'b1, 16'h0020, "hold");
  endtask
  task automatic t_touch();
    sense.magnetic_threshold = 16'sd100;
    sense.magnetic_output = 16'sd100;
    repeat (3) tick();
    rdchk(gpm_pkg::ADDR_TOUCH_STATE, 16'h0000, "mag equal");
    sense.magnetic_output = 16'sd101;
    repeat (3) tick();
    rdchk(gpm_pkg::ADDR_TOUCH_STATE, 16'h0080, "mag above");
    sense.magnetic_threshold = -16'sd300;
    sense.magnetic_output = -16'sd301;
    sense.trackpad_over = 9'h100;
    sense.trackpad_active = 9'h0ff;
    repeat (3) tick();
    rdchk(gpm_pkg::ADDR_TOUCH_STATE, 16'h0000, "pad inactive");
    sense.trackpad_active = 9'h1ff;
    repeat (3) tick();
    rdchk(gpm_pkg::ADDR_TOUCH_STATE, 16'h0002, "pad active");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    sense = '0;
    repeat (2) tick();
    rst = 1'b0;
    t_regs();
    t_power();
    t_gestures();
    t_touch();
    tally_and_finish();
  end
endmodule
